// ---- dv/sasb_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// Drives the serial port and event inputs and compares against a bench model
module sasb_top_bench;
	import sasb_pkg::*;
	logic        clk, rst, spi_sclk, spi_sen_n, spi_sdi, soft_reset;
	logic        sysref_detect, divider_realign, divider_match, osc_sync_event;
	logic        serial_link_enable, link_up, crc_mode_64b66b, sysref_misalign_div;
	logic        sysref_misalign_link, crc_mute_recovery;
	logic [15:0] link_down_time_limit, lane_enable, lane_crc_fault;
	wire         spi_sdo, spi_sdo_oe_n, alarm_out, converter_mute;
	logic [7:0]  m_sync, m_alarm, m_mask, m_mute, q;
	logic        oe_bad;
	int          n_fail, comparisons, cyc;

	sasb_top uut (.clk, .rst, .spi_sclk, .spi_sen_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
		.soft_reset, .sysref_detect, .divider_realign, .divider_match, .osc_sync_event,
		.serial_link_enable, .link_up, .link_down_time_limit, .crc_mode_64b66b,
		.lane_enable, .lane_crc_fault, .sysref_misalign_div, .sysref_misalign_link,
		.crc_mute_recovery, .alarm_out, .converter_mute);

	// 125 MHz clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// Hang guard: a full run needs well under this many cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One 24-bit frame; half periods of four clocks keep sclk well below clk/4
	task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d,
		output logic [7:0] rd_q);
		logic [23:0] f;
		f = {r, a, d};
		rd_q = 8'h00;
		oe_bad = 1'b0;
		@(posedge clk) spi_sen_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_sdi <= f[i];
			repeat (4) @(posedge clk);
			spi_sclk <= 1'b1;
			if (i < 8) begin
				rd_q[i] = spi_sdo;
				oe_bad = oe_bad | (spi_sdo_oe_n !== ~r);
			end
			repeat (4) @(posedge clk);
			spi_sclk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		spi_sen_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Data pin driven only in the data phase of a read
		oe_bad = oe_bad | (spi_sdo_oe_n !== 1'b1);
		chk("sdo_oe_n", {7'h00, oe_bad}, 8'h00);
	endtask

	// Write through the port and apply the same write to the model
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		xfer(1'b0, a, d, q);
		case (a)
			ADDR_ALARM: m_alarm = m_alarm & ~(d & ALARM_W1C);
			ADDR_MASK:  m_mask = d;
			ADDR_MUTE:  m_mute = d;
			ADDR_SYNC:  m_sync = {d[7:4], m_sync[3:0] & ~(d[3:0] & 4'hB)};
			default:    ;
		endcase
	endtask

	task automatic rd(input logic [14:0] a, input logic [7:0] exp, input string name);
		xfer(1'b1, a, 8'h00, q);
		chk(name, q, exp);
	endtask

	// Mute follows latched alarms while recovery is off
	function automatic logic [7:0] mute_exp();
		return {7'h00, (m_alarm[0] & ~m_mute[0]) | (m_alarm[5] & ~m_mute[5])};
	endfunction

	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: sysref_detect <= 1'b1;
			1: osc_sync_event <= 1'b1;
			3: divider_realign <= 1'b1;
			4: sysref_misalign_div <= 1'b1;
			5: sysref_misalign_link <= 1'b1;
			6: lane_crc_fault <= lane_enable;
			7: lane_crc_fault <= ~lane_enable;
			8: soft_reset <= 1'b1;
			default: ;
		endcase
		@(posedge clk);
		{sysref_detect, osc_sync_event, divider_realign, soft_reset} <= 4'h0;
		{sysref_misalign_div, sysref_misalign_link} <= 2'h0;
		lane_crc_fault <= 16'h0000;
		repeat (3) @(posedge clk);
	endtask

	initial begin
		{rst, spi_sclk, spi_sdi, soft_reset, sysref_detect, divider_realign} = 6'h20;
		{spi_sen_n, divider_match, osc_sync_event, serial_link_enable, link_up} = 5'h11;
		{crc_mode_64b66b, sysref_misalign_div, sysref_misalign_link} = 3'h4;
		crc_mute_recovery = 1'b0;
		link_down_time_limit = 16'h0001;
		lane_enable = 16'h0000;
		lane_crc_fault = 16'h0000;
		{n_fail, comparisons, cyc} = '0;
		{m_sync, m_alarm, m_mask, m_mute} = {8'h00, 8'h02, 8'h00, 8'h21};
		void'($urandom(32'h725D));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);

		// Reset values and the reset alarm
		chk("alarm_out", {7'h00, alarm_out}, 8'h01);
		rd(ADDR_ALARM, m_alarm, "alarm");
		rd(ADDR_MASK, 8'h00, "mask");
		rd(ADDR_MUTE, 8'h21, "mute_mask");
		wr(ADDR_ALARM, 8'h00);
		rd(ADDR_ALARM, m_alarm, "alarm_w0");
		wr(ADDR_ALARM, 8'h02);
		rd(ADDR_ALARM, m_alarm, "alarm_w1c");
		chk("alarm_out", {7'h00, alarm_out}, 8'h00);
		$display("test reset done");

		// Sync flags: set by events, cleared by one, bit 2 live
		divider_match <= 1'b1;
		pulse(0);
		pulse(1);
		pulse(3);
		m_sync = m_sync | 8'h0B;
		rd(ADDR_SYNC, m_sync | 8'h04, "sync_set");
		wr(ADDR_SYNC, 8'h5F);
		rd(ADDR_SYNC, m_sync | 8'h04, "sync_clr");
		divider_match <= 1'b0;
		pulse(0);
		m_sync = m_sync | 8'h01;
		rd(ADDR_SYNC, m_sync, "sync_rearm");
		$display("test sync done");

		// Events that must not raise alarms
		lane_enable <= 16'($urandom) | 16'h0001;
		pulse(7);
		crc_mode_64b66b <= 1'b0;
		pulse(6);
		pulse(5);
		rd(ADDR_ALARM, m_alarm, "alarm_quiet");
		// Alarm sources
		crc_mode_64b66b <= 1'b1;
		pulse(6);
		pulse(4);
		@(posedge clk) serial_link_enable <= 1'b1;
		repeat (3) @(posedge clk);
		link_up <= 1'b0;
		repeat (5) @(posedge clk);
		link_up <= 1'b1;
		pulse(5);
		serial_link_enable <= 1'b0;
		m_alarm = m_alarm | 8'hA1;
		rd(ADDR_ALARM, m_alarm, "alarm_set");
		// Link held down while enabled, limit of one tick
		link_up <= 1'b0;
		repeat (3) @(posedge clk);
		serial_link_enable <= 1'b1;
		repeat (400) @(posedge clk);
		serial_link_enable <= 1'b0;
		link_up <= 1'b1;
		m_alarm = m_alarm | 8'h40;
		wr(ADDR_ALARM, 8'h1C);
		rd(ADDR_ALARM, m_alarm, "alarm_timeout");
		$display("test alarms done");

		// Mute mask selects which alarms mute
		chk("mute", {7'h00, converter_mute}, mute_exp());
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_MUTE, 8'({i[1], 4'h0, i[0]}));
			chk("mute", {7'h00, converter_mute}, mute_exp());
		end
		$display("test mute done");

		// Alarm mask gates the alarm output
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_MASK, (i == 0) ? 8'hFF : 8'($urandom));
			chk("alarm_out", {7'h00, alarm_out},
				{7'h00, |(m_alarm & ~m_mask & ALARM_W1C)});
		end
		wr(ADDR_ALARM, 8'hFF);
		rd(ADDR_ALARM, m_alarm, "alarm_clr");
		// A live CRC fault outlasts its clear, and under recovery mutes directly
		crc_mute_recovery <= 1'b1;
		wr(ADDR_MUTE, 8'h01);
		lane_crc_fault <= lane_enable;
		wr(ADDR_ALARM, 8'h20);
		m_alarm = m_alarm | 8'h20;
		rd(ADDR_ALARM, m_alarm, "alarm_set_wins");
		chk("mute_live", {7'h00, converter_mute}, 8'h01);
		lane_crc_fault <= 16'h0000;
		repeat (3) @(posedge clk);
		chk("mute_live", {7'h00, converter_mute}, 8'h00);
		wr(ADDR_ALARM, 8'h20);
		rd(ADDR_ALARM, m_alarm, "alarm_live_clr");
		$display("test mask done");

		// Software reset restores defaults and flags the reset
		pulse(8);
		{m_alarm, m_mask, m_mute} = {8'h02, 8'h00, 8'h21};
		rd(ADDR_ALARM, m_alarm, "alarm_soft");
		rd(ADDR_MASK, m_mask, "mask_soft");
		rd(ADDR_MUTE, m_mute, "mute_soft");
		$display("test soft reset done");
		summarize();
	end
endmodule
`default_nettype wire

// ---- hdl/sasb_flag_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carries set and clear strobes to a sticky flag bank and its contents back
interface sasb_flag_if;
	logic [7:0] set_evt;
	logic [7:0] clr;
	logic [7:0] flags;
	modport bank (input set_evt, input clr, output flags);
	modport user (output set_evt, output clr, input flags);
endinterface
`default_nettype wire

// ---- hdl/sasb_link_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Measures link-down time in microsecond ticks and fires once past the limit
module sasb_link_timer
	import sasb_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        link_up,
	input wire logic        serial_link_enable,
	input wire logic [15:0] link_down_time_limit,
	output logic            expire
);
	logic [7:0]  div_cnt;
	logic [15:0] down_ticks;
	logic        fired;
	wire         tick    = (div_cnt == TICK_CYC - 8'h01);
	wire         counting = serial_link_enable & ~link_up;
	// Gated by counting so a zero limit cannot fire while the link is up
	wire         over    = tick & counting & (down_ticks == link_down_time_limit) & ~fired;

	// Divider gives one tick enable per microsecond
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
		end
	end

	// Count resets whenever the link comes up or is disabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			down_ticks <= 16'h0000;
			fired      <= 1'b0;
			expire     <= 1'b0;
		end else begin
			expire <= over;
			if (!counting) begin
				down_ticks <= 16'h0000;
				fired      <= 1'b0;
			end else begin
				if (over) begin
					fired <= 1'b1;
				end
				if (tick && down_ticks != 16'hFFFF) begin
					down_ticks <= down_ticks + 16'h0001;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- hdl/sasb_pkg.sv ----
// Overview of operation
// - Divider realignment to SYSREF sets sync status bit 3 until software writes one.
// - Sync status bit 2 shows live divider match; read-only, writes never clear it.
// - Any oscillator sync event sets sync status bit 1; write one clears it.
// - SYSREF detection sets bit 0; write one clears and re-arms detection.
// - Link-up falling while link enabled sets alarm bit 7; write one clears.
// - Link down beyond programmed limit while enabled sets alarm bit 6.
// - CRC fault on enabled lane in 64b/66b mode sets alarm bit 5.
// - Any chip reset, pin, power-on or soft, sets alarm bit 1.
// - Misaligned SYSREF from dividers, or link when enabled, sets alarm bit 0.
// - Alarm bits 4 to 2 are reserved, read-only zero, never set.
// - A set mask bit keeps its alarm off the alarm output.
// - Alarm mask register at 0431h resets to 00h.
// - Mute mask register at 0432h resets to 21h.
// - Alarm status at 0430h; every alarm sticky until written one.
// - SYSREF misalignment alarm mutes converters unless mute mask bit 0 set.
// - CRC alarms mute converters per recovery setting unless mute mask bit 5 set.
package sasb_pkg;
	// Serial frame: read flag, 15 address bits, 8 data bits
	localparam int          FRAME_BITS = 24;
	localparam int          ADDR_BITS  = 15;
	localparam logic [4:0]  CNT_ADDR   = 5'h10;
	localparam logic [4:0]  CNT_LAST   = 5'h17;
	localparam logic [4:0]  CNT_DONE   = 5'h18;

	// Register offsets
	localparam logic [14:0] ADDR_SYNC  = 15'h0410;
	localparam logic [14:0] ADDR_ALARM = 15'h0430;
	localparam logic [14:0] ADDR_MASK  = 15'h0431;
	localparam logic [14:0] ADDR_MUTE  = 15'h0432;

	// Sync status fields
	localparam int SYNC_REALIGN = 3;
	localparam int SYNC_MATCH   = 2;
	localparam int SYNC_OSC     = 1;
	localparam int SYNC_SYSREF  = 0;
	localparam logic [7:0] SYNC_W1C   = 8'h0B;
	localparam logic [7:0] SYNC_SPARE = 8'hF0;

	// Alarm fields, shared by status, mask and mute mask
	localparam int ALM_LINK_LOSS = 7;
	localparam int ALM_TIMEOUT   = 6;
	localparam int ALM_CRC       = 5;
	localparam int ALM_RESET     = 1;
	localparam int ALM_MISALIGN  = 0;
	localparam logic [7:0] ALARM_W1C = 8'hE3;

	// Reset values
	localparam logic [7:0] SYNC_RST  = 8'h00;
	localparam logic [7:0] ALARM_RST = 8'h02;
	localparam logic [7:0] MASK_RST  = 8'h00;
	localparam logic [7:0] MUTE_RST  = 8'h21;

	// Link-down timer runs in microsecond ticks
	localparam int         CLK_PERIOD_NS = 8;
	localparam int         TICK_NS       = 1000;
	localparam int         TICK_CYC_INT  = TICK_NS / CLK_PERIOD_NS;
	localparam logic [7:0] TICK_CYC      = 8'(TICK_CYC_INT);
endpackage

// ---- hdl/sasb_sticky.sv ----
`timescale 1ns/1ps
`default_nettype none
// Byte of sticky flags, set by hardware and cleared by write-one strobes
module sasb_sticky #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input wire logic    clk,
	input wire logic    rst,
	sasb_flag_if.bank   fl
);
	// Set is ORed after the clear so a coincident event survives
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fl.flags <= RST_VAL;
		end else begin
			fl.flags <= (fl.flags & ~fl.clr) | fl.set_evt;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/sasb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Sync status, system alarm, alarm mask and mute mask behind the serial control port
module sasb_top
	import sasb_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        spi_sclk,
	input wire logic        spi_sen_n,
	input wire logic        spi_sdi,
	output logic            spi_sdo,
	output logic            spi_sdo_oe_n,
	input wire logic        soft_reset,
	input wire logic        sysref_detect,
	input wire logic        divider_realign,
	input wire logic        divider_match,
	input wire logic        osc_sync_event,
	input wire logic        serial_link_enable,
	input wire logic        link_up,
	input wire logic [15:0] link_down_time_limit,
	input wire logic        crc_mode_64b66b,
	input wire logic [15:0] lane_enable,
	input wire logic [15:0] lane_crc_fault,
	input wire logic        sysref_misalign_div,
	input wire logic        sysref_misalign_link,
	input wire logic        crc_mute_recovery,
	output logic            alarm_out,
	output logic            converter_mute
);
	// Serial port state
	logic        sclk_q;
	logic [4:0]  bit_cnt;
	logic [22:0] shift_in;
	logic [7:0]  shift_out;
	logic        read_frame;

	// Software-owned registers, link-up history and timer expiry
	logic [7:0]  alarm_mask;
	logic [7:0]  mute_mask;
	logic [3:0]  sync_spare;
	logic        link_up_q;
	logic        timer_expire;

	sasb_flag_if sync_fl ();
	sasb_flag_if alarm_fl ();

	// Edge detection of the serial clock, only inside a frame
	wire sclk_rise = spi_sclk & ~sclk_q & ~spi_sen_n;
	wire sclk_fall = ~spi_sclk & sclk_q & ~spi_sen_n;

	// Fields of the frame as seen at the final rising edge; rd_addr as seen after the sixteenth rising edge
	wire         frame_rd = shift_in[22];
	wire [14:0]  wr_addr  = shift_in[21:7];
	wire [7:0]   wr_data  = {shift_in[6:0], spi_sdi};
	wire [14:0]  rd_addr  = shift_in[14:0];
	wire         wr_stb   = sclk_rise & (bit_cnt == CNT_LAST) & ~frame_rd;

	// Write decode
	wire wr_sync  = wr_stb & (wr_addr == ADDR_SYNC);
	wire wr_alarm = wr_stb & (wr_addr == ADDR_ALARM);
	wire wr_mask  = wr_stb & (wr_addr == ADDR_MASK);
	wire wr_mute  = wr_stb & (wr_addr == ADDR_MUTE);

	// Readable views of the two status bytes
	wire [7:0] sync_view  = {sync_spare, sync_fl.flags[SYNC_REALIGN], divider_match,
		sync_fl.flags[SYNC_OSC], sync_fl.flags[SYNC_SYSREF]};
	wire [7:0] alarm_view = alarm_fl.flags & ALARM_W1C;

	// Read mux; unmapped addresses read as zero
	function automatic logic [7:0] read_reg(input logic [14:0] a, input logic [7:0] s,
		input logic [7:0] al, input logic [7:0] mk, input logic [7:0] mu);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			ADDR_SYNC:  r = s;
			ADDR_ALARM: r = al;
			ADDR_MASK:  r = mk;
			ADDR_MUTE:  r = mu;
			default:    r = 8'h00;
		endcase
		return r;
	endfunction

	wire [7:0] rd_data = read_reg(rd_addr, sync_view, alarm_view, alarm_mask, mute_mask);

	// Frame bit counter and input shifter; a raised enable aborts the frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_q   <= 1'b0;
			bit_cnt  <= 5'h00;
			shift_in <= 23'h000000;
		end else begin
			sclk_q <= spi_sclk;
			if (spi_sen_n) begin
				bit_cnt <= 5'h00;
			end else if (sclk_rise && bit_cnt != CNT_DONE) begin
				bit_cnt  <= bit_cnt + 5'h01;
				shift_in <= {shift_in[21:0], spi_sdi};
			end
		end
	end

	// Read data is fetched after the address and driven on falling edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_out  <= 8'h00;
			read_frame <= 1'b0;
		end else if (spi_sen_n) begin
			read_frame <= 1'b0;
		end else if (sclk_fall && bit_cnt == CNT_ADDR) begin
			shift_out  <= rd_data;
			read_frame <= shift_in[15];
		end else if (sclk_fall && bit_cnt > CNT_ADDR) begin
			shift_out <= {shift_out[6:0], 1'b0};
		end
	end

	// The data pin is driven only during the data phase of a read
	assign spi_sdo      = shift_out[7];
	assign spi_sdo_oe_n = ~(read_frame & ~spi_sen_n);

	// Plain read/write registers; soft reset returns them to defaults
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarm_mask <= MASK_RST;
			mute_mask  <= MUTE_RST;
			sync_spare <= SYNC_RST[7:4];
		end else if (soft_reset) begin
			alarm_mask <= MASK_RST;
			mute_mask  <= MUTE_RST;
			sync_spare <= SYNC_RST[7:4];
		end else begin
			if (wr_mask) begin
				alarm_mask <= wr_data;
			end
			if (wr_mute) begin
				mute_mask <= wr_data;
			end
			if (wr_sync) begin
				sync_spare <= wr_data[7:4];
			end
		end
	end

	// Sync status events; only ones in the written byte clear
	assign sync_fl.set_evt = {4'h0, divider_realign, 1'b0, osc_sync_event, sysref_detect};
	assign sync_fl.clr     = (wr_sync ? (wr_data & SYNC_W1C) : 8'h00)
		| (soft_reset ? 8'hFF : 8'h00);

	sasb_sticky #(
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.fl  (sync_fl)
	);

	// Previous link state for the falling edge of link-up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_up_q <= 1'b0;
		end else begin
			link_up_q <= link_up;
		end
	end

	sasb_link_timer u_timer (
		.clk                  (clk),
		.rst                  (rst),
		.link_up              (link_up),
		.serial_link_enable   (serial_link_enable),
		.link_down_time_limit (link_down_time_limit),
		.expire               (timer_expire)
	);

	// Alarm events
	wire ev_link_loss = link_up_q & ~link_up & serial_link_enable;
	wire ev_crc       = crc_mode_64b66b & |(lane_enable & lane_crc_fault);
	wire ev_misalign  = sysref_misalign_div | (serial_link_enable & sysref_misalign_link);

	// Pin and power-on reset load the reset alarm through the reset value
	assign alarm_fl.set_evt = {ev_link_loss, timer_expire, ev_crc, 3'b000,
		soft_reset, ev_misalign};
	assign alarm_fl.clr     = (wr_alarm ? (wr_data & ALARM_W1C) : 8'h00)
		| (soft_reset ? 8'hFF : 8'h00);

	sasb_sticky #(
		.RST_VAL (ALARM_RST)
	) u_alarm (
		.clk (clk),
		.rst (rst),
		.fl  (alarm_fl)
	);

	// Mute sources: misalignment alarm, and CRC either latched or live per recovery
	wire crc_mute_src = crc_mute_recovery ? ev_crc : alarm_view[ALM_CRC];
	wire next_mute    = (alarm_view[ALM_MISALIGN] & ~mute_mask[ALM_MISALIGN])
		| (crc_mute_src & ~mute_mask[ALM_CRC]);
	wire next_alarm   = |(alarm_view & ~alarm_mask & ALARM_W1C);

	// Outputs registered so they never glitch while the status byte updates
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			alarm_out      <= 1'b0;
			converter_mute <= 1'b0;
		end else begin
			alarm_out      <= next_alarm;
			converter_mute <= next_mute;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_sysref_clear;
		wr_sync && wr_data[SYNC_SYSREF] && !sysref_detect && !soft_reset;
	endsequence
	sequence s_sysref_again;
		!sync_fl.flags[SYNC_SYSREF] ##0 sysref_detect;
	endsequence
	sequence s_w1c_alarm;
		wr_alarm && (wr_data & ALARM_W1C) != 8'h00 && alarm_fl.set_evt == 8'h00;
	endsequence
	sequence s_rd_load;
		sclk_fall && bit_cnt == CNT_ADDR;
	endsequence

	property p_realign;
		divider_realign |=> sync_fl.flags[SYNC_REALIGN] && sync_view[SYNC_REALIGN];
	endproperty
	a_realign: assert property (p_realign) else $error("realign flag not set");

	property p_match_ro;
		s_rd_load ##0 (rd_addr == ADDR_SYNC) |=> shift_out[SYNC_MATCH] == $past(divider_match);
	endproperty
	a_match_ro: assert property (p_match_ro) else $error("match bit not live");

	property p_osc;
		osc_sync_event |=> sync_view[SYNC_OSC];
	endproperty
	a_osc: assert property (p_osc) else $error("osc sync flag not set");

	property p_rearm;
		s_sysref_clear |=> !sync_view[SYNC_SYSREF];
	endproperty
	a_rearm: assert property (p_rearm) else $error("sysref flag not cleared");

	property p_sysref_set;
		s_sysref_again |=> sync_view[SYNC_SYSREF];
	endproperty
	a_sysref_set: assert property (p_sysref_set) else $error("sysref flag not re-armed");

	property p_link_loss;
		$fell(link_up) && serial_link_enable |=> alarm_view[ALM_LINK_LOSS];
	endproperty
	a_link_loss: assert property (p_link_loss) else $error("link loss alarm missing");

	property p_timeout;
		timer_expire |=> alarm_view[ALM_TIMEOUT] ##1 (!link_up || !timer_expire);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout alarm missing");

	property p_crc;
		crc_mode_64b66b && |(lane_enable & lane_crc_fault) |=> alarm_view[ALM_CRC];
	endproperty
	a_crc: assert property (p_crc) else $error("crc alarm missing");

	property p_soft_rst;
		soft_reset |=> alarm_view == (ALARM_RST | ($past(alarm_fl.set_evt) & ALARM_W1C))
			&& alarm_mask == MASK_RST && mute_mask == MUTE_RST;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset state wrong");

	property p_reserved;
		alarm_fl.flags[4:2] == 3'b000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved alarm bits set");

	property p_alarm_out;
		!rst |=> alarm_out == |($past(alarm_view) & ~$past(alarm_mask));
	endproperty
	a_alarm_out: assert property (p_alarm_out) else $error("alarm output wrong");

	property p_mask_wr;
		wr_mask && !soft_reset |=> alarm_mask == $past(wr_data);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

	property p_w1c;
		s_w1c_alarm |=> (alarm_view & $past(wr_data) & ALARM_W1C) == 8'h00;
	endproperty
	a_w1c: assert property (p_w1c) else $error("alarm not cleared");

	property p_mute;
		alarm_view[ALM_MISALIGN] && !mute_mask[ALM_MISALIGN] |=> converter_mute;
	endproperty
	a_mute: assert property (p_mute) else $error("misalign did not mute");

	property p_crc_mute;
		!crc_mute_recovery && alarm_view[ALM_CRC] && !mute_mask[ALM_CRC] |=> converter_mute;
	endproperty
	a_crc_mute: assert property (p_crc_mute) else $error("crc did not mute");

	property p_zero_write;
		wr_alarm && wr_data == 8'h00 && !soft_reset
			|=> alarm_fl.flags == ($past(alarm_fl.flags) | $past(alarm_fl.set_evt));
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write changed alarms");

	property p_set_wins;
		wr_alarm && !soft_reset && (alarm_fl.set_evt & wr_data) != 8'h00
			|=> (alarm_fl.flags & $past(alarm_fl.set_evt)) == $past(alarm_fl.set_evt);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

	// Link-side misalignment is ignored while the serial link is off
	property p_misalign_gate;
		sysref_misalign_link && !serial_link_enable && !sysref_misalign_div
			&& !alarm_fl.flags[ALM_MISALIGN] |=> !alarm_fl.flags[ALM_MISALIGN];
	endproperty
	a_misalign_gate: assert property (p_misalign_gate) else $error("link misalign leaked");

	// Outside 64b/66b modes a lane fault never raises the CRC alarm
	property p_crc_mode_off;
		!crc_mode_64b66b && !alarm_fl.flags[ALM_CRC] |=> !alarm_fl.flags[ALM_CRC];
	endproperty
	a_crc_mode_off: assert property (p_crc_mode_off) else $error("crc alarm outside mode");

	// With recovery on, a live fault mutes even before the alarm is read
	property p_mute_live;
		crc_mute_recovery && ev_crc && !mute_mask[ALM_CRC] |=> converter_mute;
	endproperty
	a_mute_live: assert property (p_mute_live) else $error("live crc did not mute");

	property p_rd_mask;
		s_rd_load ##0 (rd_addr == ADDR_MASK) |=> shift_out == $past(alarm_mask);
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

	property p_rd_mute;
		s_rd_load ##0 (rd_addr == ADDR_MUTE) |=> shift_out == $past(mute_mask);
	endproperty
	a_rd_mute: assert property (p_rd_mute) else $error("mute mask read wrong");

	property p_rd_alarm;
		s_rd_load ##0 (rd_addr == ADDR_ALARM) |=> shift_out[4:2] == 3'b000;
	endproperty
	a_rd_alarm: assert property (p_rd_alarm) else $error("reserved bits read set");
endmodule
`default_nettype wire
